// File: dv/group_selector_block_bench.sv
/* Self-checking bench for the group selector: stimulus goes through the far-side
   model, expected results wait in a queue. Assumes the ports declared in hw/. */
`timescale 1ns/1ps
// ****
// Bench top
// ****
module group_selector_block_bench;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] group_request, active_onehot;
	logic [2:0] enabled_group_count, active_group;
	logic force_override_enable, remote_refused, request_ignored;
	logic [3:0] forced_group_choice, remote_group_choice;
	logic [4:0] e;
	logic [4:0] q[$];
	int n_fail = 0;
	int checks_done = 0;
	int g;
	always #5 core_clk = ~core_clk;
	request_source p (.group_request(group_request), .enabled_group_count(enabled_group_count),
		.force_override_enable(force_override_enable), .forced_group_choice(forced_group_choice),
		.remote_group_choice(remote_group_choice));
	group_selector_block uut (.core_clk(core_clk), .arst_n(arst_n), .group_request(group_request),
		.enabled_group_count(enabled_group_count), .force_override_enable(force_override_enable),
		.forced_group_choice(forced_group_choice), .remote_group_choice(remote_group_choice),
		.active_group(active_group), .active_onehot(active_onehot),
		.remote_refused(remote_refused), .request_ignored(request_ignored));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One cycle per call; the request stays on the line until the next call writes a new one
	task automatic step(input logic [7:0] req, input logic [2:0] grp, input logic rf,
		input logic ig);
		p.group_request = req;
		@(posedge core_clk);
		q.push_back({ig, rf, grp});
		#1;
	endtask
	task automatic end_sim();
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Results land on the sampling edge; look half a cycle later
	always @(negedge core_clk) begin
		if (q.size() > 0) begin
			e = q.pop_front();
			chk("active_group", {5'h00, active_group}, {5'h00, e[2:0]});
			chk("active_onehot", active_onehot, 8'h01 << e[2:0]);
			chk("remote_refused", {7'h00, remote_refused}, {7'h00, e[3]});
			chk("request_ignored", {7'h00, request_ignored}, {7'h00, e[4]});
		end
	end
	initial begin
		void'($urandom(32'h2DB329D5));
		repeat (20) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		step(8'h00, 3'h0, 1'b0, 1'b0);
		step(8'h04, 3'h0, 1'b0, 1'b1);
		step(8'h00, 3'h0, 1'b0, 1'b0);
		p.enabled_group_count = 3'h7;
		step(8'h04, 3'h2, 1'b0, 1'b0);
		step(8'h00, 3'h2, 1'b0, 1'b0);
		repeat (6) begin
			g = $urandom_range(7, 0);
			step(8'h01 << g, g[2:0], 1'b0, 1'b0);
		end
		step(8'h12, 3'h1, 1'b0, 1'b0);
		step(8'h12, 3'h1, 1'b0, 1'b0);
		step(8'h0A, 3'h1, 1'b0, 1'b0);
		p.remote_group_choice = 4'h5;
		step(8'h02, 3'h1, 1'b1, 1'b0);
		step(8'h00, 3'h1, 1'b0, 1'b0);
		p.remote_group_choice = 4'h3;
		step(8'h00, 3'h2, 1'b0, 1'b0);
		p.force_override_enable = 1'b1;
		p.forced_group_choice = 4'h6;
		step(8'h01, 3'h5, 1'b0, 1'b0);
		step(8'h01, 3'h5, 1'b0, 1'b0);
		p.force_override_enable = 1'b0;
		step(8'h00, 3'h5, 1'b0, 1'b0);
		p.force_override_enable = 1'b1;
		p.forced_group_choice = 4'h2;
		step(8'h08, 3'h1, 1'b0, 1'b0);
		step(8'h08, 3'h1, 1'b0, 1'b0);
		p.force_override_enable = 1'b0;
		step(8'h08, 3'h3, 1'b0, 1'b0);
		p.enabled_group_count = 3'h2;
		step(8'h10, 3'h0, 1'b0, 1'b1);
		p.remote_group_choice = 4'h8;
		step(8'h00, 3'h0, 1'b1, 1'b0);
		p.force_override_enable = 1'b1;
		p.forced_group_choice = 4'h7;
		step(8'h00, 3'h0, 1'b0, 1'b1);
		step(8'h00, 3'h0, 1'b0, 1'b0);
		repeat (2) @(posedge core_clk);
		end_sim();
	end
endmodule // group_selector_block_bench

// File: dv/request_source.sv
/* Far-side model: the request lines and operator settings seen by the selector.
   Assumes the bench writes its outputs a little after the rising clock edge. */
`timescale 1ns/1ps
// ****
// Request and setting sources
// ****
module request_source (
	// Lines toward the selector
	output logic [7:0] group_request,
	output logic [2:0] enabled_group_count,
	output logic force_override_enable,
	output logic [3:0] forced_group_choice,
	output logic [3:0] remote_group_choice
);
	// Operator may only force once the override is switched on
	initial begin
		group_request = 8'h00;
		enabled_group_count = 3'h0;
		force_override_enable = 1'b0;
		forced_group_choice = 4'h0;
		remote_group_choice = 4'h0;
	end
endmodule // request_source

// File: hw/group_selector_block.sv
/*
 * Setting group selector: resolves eight group requests, a remote request
 * and a force override into one active group.
 * Assumes all inputs except arst_n are synchronous to core_clk and settings are static
 * levels held by the controlling party.
 */
`timescale 1ns/1ps
module group_selector_block (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Group request inputs, bit 0 is group one
	input wire logic [7:0] group_request,
	// Settings
	input wire logic [2:0] enabled_group_count,
	input wire logic force_override_enable,
	input wire logic [3:0] forced_group_choice,
	input wire logic [3:0] remote_group_choice,
	// Status
	output logic [2:0] active_group,
	output logic [7:0] active_onehot,
	output logic remote_refused,
	output logic request_ignored
);
	// **********************************************************************
	// Request resolution
	// **********************************************************************
	logic [7:0] enabled_mask;
	logic [7:0] req_q;
	logic [7:0] req_d;
	logic [7:0] valid_req;
	logic [7:0] rise;
	logic [7:0] held;
	logic [7:0] cand;
	logic [7:0] higher_held;
	logic [3:0] force_prev_q;
	logic [3:0] force_prev_d;
	logic [3:0] remote_prev_q;
	logic [3:0] remote_prev_d;
	logic [2:0] active_q;
	logic [2:0] active_d;
	logic [7:0] onehot_q;
	logic [7:0] onehot_d;
	logic refused_q;
	logic refused_d;
	logic ignored_q;
	logic ignored_d;
	logic [2:0] remote_idx;
	logic [2:0] force_idx;
	logic remote_new;
	logic force_new;
	logic force_ok;
	logic remote_ok;

	genvar gi;
	generate
		for (gi = 0; gi < group_sel_pkg::GROUP_COUNT; gi++) begin : g_req
			assign enabled_mask[gi] = (3'(gi) <= enabled_group_count); // see [RULE_14]
			assign valid_req[gi] = group_request[gi] & enabled_mask[gi]; // see [RULE_18]
			// Pulse: rising edge; static: level held from the previous cycle
			assign rise[gi] = valid_req[gi] & ~req_q[gi]; // see [RULE_05]
			assign held[gi] = valid_req[gi] & req_q[gi];
			assign cand[gi] = rise[gi] | held[gi];
			if (gi == 0) begin : g_first
				assign higher_held[gi] = 1'b0;
			end else begin : g_rest
				assign higher_held[gi] = |held[gi-1:0]; // see [RULE_17]
			end
		end
	endgenerate

	assign remote_idx = 3'(remote_group_choice - 4'h1);
	assign force_idx = 3'(forced_group_choice - 4'h1);
	// Remote and force act only on a fresh write of a group number
	assign remote_new = (remote_group_choice != remote_prev_q) &&
		(remote_group_choice != group_sel_pkg::CHOICE_NONE) &&
		(remote_group_choice <= 4'h8);
	assign force_new = (forced_group_choice != force_prev_q) &&
		(forced_group_choice != group_sel_pkg::CHOICE_NONE) &&
		(forced_group_choice <= 4'h8);
	assign force_ok = force_new && force_override_enable && enabled_mask[force_idx]; // see [RULE_09]
	assign remote_ok = remote_new && enabled_mask[remote_idx] &&
		!higher_held[remote_idx]; // see [RULE_15] [RULE_17]

	// **********************************************************************
	// Selection
	// **********************************************************************
	always_comb begin
		req_d = valid_req;
		force_prev_d = forced_group_choice;
		remote_prev_d = remote_group_choice;
		active_d = active_q;
		refused_d = 1'b0;
		ignored_d = |(group_request & ~enabled_mask); // see [RULE_18]
		if (force_override_enable) begin
			// Automatic control is set aside while forcing
			if (force_ok) begin
				active_d = force_idx; // see [RULE_08] [RULE_10]
			end
			if (force_new && !enabled_mask[force_idx]) begin
				ignored_d = 1'b1;
			end
		end else if (enabled_group_count != group_sel_pkg::USED_RESET) begin // see [RULE_03]
			// Lowest set bit wins: group one ranks highest
			if (|cand) begin
				for (int i = 7; i >= 0; i--) begin
					if (cand[i]) begin
						active_d = 3'(i); // see [RULE_04] [RULE_06] [RULE_07] [RULE_12]
					end
				end
			end else if (remote_ok) begin
				active_d = remote_idx; // see [RULE_15]
			end
			// Refused only if the target is disabled or a higher group is held; a winning request drops it unflagged, not queued
			if (remote_new && !remote_ok) begin
				refused_d = 1'b1; // see [RULE_15]
			end
			// No request keeps the last group, forced or not: see [RULE_11]
		end else begin
			active_d = group_sel_pkg::ACTIVE_RESET; // see [RULE_02]
		end
		if (!enabled_mask[active_d]) begin
			active_d = group_sel_pkg::ACTIVE_RESET;
		end
		onehot_d = group_sel_pkg::GROUP_ONE_BIT << active_d; // see [RULE_01]
	end

	// **********************************************************************
	// Registers
	// **********************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= 8'h00;
			force_prev_q <= group_sel_pkg::CHOICE_NONE; // see [RULE_10] [RULE_13]
			remote_prev_q <= group_sel_pkg::CHOICE_NONE;
			active_q <= group_sel_pkg::ACTIVE_RESET; // see [RULE_16]
			onehot_q <= group_sel_pkg::ONEHOT_RESET;
			refused_q <= 1'b0;
			ignored_q <= 1'b0;
		end else begin
			req_q <= req_d;
			force_prev_q <= force_prev_d;
			remote_prev_q <= remote_prev_d;
			active_q <= active_d;
			onehot_q <= onehot_d;
			refused_q <= refused_d;
			ignored_q <= ignored_d;
		end
	end

	// **********************************************************************
	// Output drive
	// **********************************************************************
	assign active_group = active_q;
	assign active_onehot = onehot_q;
	assign remote_refused = refused_q;
	assign request_ignored = ignored_q;

	// **********************************************************************
	// Assertions
	// **********************************************************************
	onehot_valid_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_01]
		$onehot(active_onehot) && active_onehot[active_group])
		else $error("active group indication not one-hot or mismatched");
	single_group_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_02]
		enabled_group_count == 3'h0 |=> active_group == 3'h0)
		else $error("group one not active with one group enabled");
	prio_static_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_17]
		!force_override_enable && enabled_group_count != 3'h0 && held[0]
		|=> active_group == 3'h0)
		else $error("held group one did not win");
	pulse_take_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_07]
		!force_override_enable && enabled_group_count == 3'h7 && rise[1] && !cand[0]
		|=> active_group == 3'h1)
		else $error("pulse on group two not taken");
	latch_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_11]
		!force_override_enable && cand == 8'h00 && !remote_new && enabled_mask[active_group]
		|=> $stable(active_group))
		else $error("active group changed without a request");
	lowest_wins_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_06]
		!force_override_enable && enabled_group_count != 3'h0 && cand != 8'h00
		|=> active_onehot == $past(cand & ~(cand - 8'h01)))
		else $error("lowest requested group did not win");
	release_take_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_12]
		$fell(force_override_enable) && enabled_group_count != 3'h0 && cand != 8'h00
		|=> active_onehot == $past(cand & ~(cand - 8'h01)))
		else $error("requests not taken back at force release");
	force_apply_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_08]
		force_ok |=> active_group == $past(force_idx))
		else $error("forced group not applied");
	force_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_09]
		force_override_enable && !force_new && enabled_mask[active_group]
		|=> $stable(active_group))
		else $error("automatic change during force");
	force_ignore_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_09]
		force_override_enable && force_new && !enabled_mask[force_idx] &&
		enabled_mask[active_group]
		|=> $stable(active_group) && request_ignored)
		else $error("force to a disabled group not ignored");
	beyond_count_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_18]
		1'b1 |=> active_group <= $past(enabled_group_count) || active_group == 3'h0)
		else $error("active group beyond enabled count");
	remote_block_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_15]
		remote_refused |-> $past(remote_new))
		else $error("refusal without remote request");
	refuse_held_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_15]
		!force_override_enable && enabled_group_count != 3'h0 && remote_new &&
		higher_held[remote_idx] |=> remote_refused)
		else $error("remote request not refused under a higher hold");
	remote_take_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_15]
		!force_override_enable && enabled_group_count != 3'h0 && cand == 8'h00 && remote_ok
		|=> active_group == $past(remote_idx))
		else $error("accepted remote request not applied");
	ignore_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RULE_18]
		(group_request & ~enabled_mask) != 8'h00 |=> request_ignored)
		else $error("request to a disabled group not flagged");
	cov_pulse_c: cover property (@(posedge core_clk) disable iff (!arst_n)
		rise[2] ##1 active_group == 3'h2);
	cov_force_c: cover property (@(posedge core_clk) disable iff (!arst_n)
		force_ok ##1 !force_override_enable);
	cov_remote_c: cover property (@(posedge core_clk) disable iff (!arst_n) remote_refused);
	cov_release_c: cover property (@(posedge core_clk) disable iff (!arst_n)
		$fell(force_override_enable) && held != 8'h00);
endmodule // group_selector_block

// File: include/group_sel_pkg.sv
/*
 * Constants for the setting group selector.
 * Assumes one 100 MHz clock and an asynchronous active-low reset.
 */
// Functional notes
// [RULE_01] Eight setting groups exist; exactly one is active at any time.
// [RULE_02] By default only group one is enabled and active; selection stays idle.
// [RULE_03] With several groups enabled, requests decide which group is active.
// [RULE_04] Priority is fixed: group one highest, group eight lowest.
// [RULE_05] Each request input may be a one-cycle pulse or a held level.
// [RULE_06] Several static levels at once: the highest-priority group becomes active.
// [RULE_07] A pulse-selected group stays active until another group is requested.
// [RULE_08] While force is enabled, automatic control is ignored; forced choice is applied.
// [RULE_09] A forced change acts only if the target is enabled and force is on.
// [RULE_10] Force choice is none or groups one to eight, default none, pulse-like.
// [RULE_11] After force release with no request, the last forced group stays active.
// [RULE_12] Static levels present at force release take selection back at once.
// [RULE_13] Controller must enable force before any operator change; default disabled.
// [RULE_14] Used-groups setting enables groups one to N; new groups take defaults.
// [RULE_15] Remote change request is refused while a higher group is held by a signal.
// [RULE_16] A read-only output shows the active group, group one after reset.
// [RULE_17] A static hold blocks only lower-priority requests; group one blocks all.
// [RULE_18] Requests for groups beyond the enabled count are ignored.
package group_sel_pkg;
	localparam int unsigned GROUP_COUNT = 8;
	localparam int unsigned GROUP_IDX_W = 3;
	// Selection codes: 0 means none, 1..8 name a group
	localparam logic [3:0] CHOICE_NONE = 4'h0;
	// Enabled count code: value k enables groups one to k+1
	localparam logic [2:0] USED_RESET = 3'h0;
	localparam logic [2:0] ACTIVE_RESET = 3'h0;
	localparam logic [7:0] ONEHOT_RESET = 8'h01;
	localparam logic [7:0] GROUP_ONE_BIT = 8'h01;
endpackage
